/* File: chsw_pkg.sv */
// package: constants of the two-channel bus switch control block
package chsw_pkg;
  localparam int         CTRL_W        = 8;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam int         CH0_EN_POS    = 0;
  localparam int         CH1_EN_POS    = 1;
  localparam int         IRQ0_POS      = 4;
  localparam int         IRQ1_POS      = 5;
  localparam int         RW_POS        = 0;
  localparam logic [4:0] ADDR_FIX_DEF  = 5'h0e;
  localparam int         SYNC_STAGES   = 2;
  localparam logic [3:0] BIT_COUNT_TOP = 4'h8;
  // minimum reset pulse width, in ns, and its cycle count at 100 MHz
  localparam int         RESET_MIN_NS  = 500;
  localparam int         CLK_MHZ       = 100;
  localparam int         RESET_CYCLES  = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int         RST_CNT_W     = 8;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK}
    link_state_t;
endpackage

/* File: chsw_ctrl.sv */
// top: serial-target control of a two-channel bus switch with interrupt combining
`timescale 1ns/1ps
// Function
// - Upstream clock and data connect to either or both downstream pairs per control byte.
// - Combined interrupt equals AND of the two active-low interrupt inputs.
// - Combined interrupt is open-drain: driven low on interrupt, released otherwise.
// - Reset pin idles the serial machine and deselects all channels.
// - Two address-select pins form the low slave-address bits.
// - Last address bit is direction: 1 read, 0 write.
// - Each written byte after address is stored; last one is kept.
// - Control register is writable and readable over the serial bus.
// - Bit 0 enables channel 0, bit 1 channel 1; other bits ignored.
// - New channel selection applies only after a stop condition.
// - Control register is zero after power-up or reset.
// - Both channels may be enabled together.
// - Read returns current channel enables in the two low bits.
// - Read bits 4 and 5 show pending interrupt on channels 0 and 1.
// - Interrupt inputs are captured at the time of the read.
// - Interrupts are reported whether or not the channel is selected.
// - Both interrupt bits may read set at once.
// - Interrupt inputs double as general-purpose inputs via the status bits.
// - Serial logic works from zero up to 400 kHz clock.
// - Reset pin honoured only after it stays low the minimum pulse width.
module chsw_ctrl #(
  parameter logic [4:0] ADDR_FIX = chsw_pkg::ADDR_FIX_DEF
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic reset_pin_n,
  input  wire logic addr_sel_lo,
  input  wire logic addr_sel_hi,
  input  wire logic irq_in_ch0_n,
  input  wire logic irq_in_ch1_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  output logic      irq_out,
  output logic      irq_oe,
  output logic      down_clk_ch0_oe,
  output logic      down_data_ch0_oe,
  output logic      down_clk_ch1_oe,
  output logic      down_data_ch1_oe,
  output logic      ch0_connected,
  output logic      ch1_connected
);
  import chsw_pkg::*;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] sync_rst;
  logic [SYNC_STAGES-1:0] sync_irq0;
  logic [SYNC_STAGES-1:0] sync_irq1;
  logic [SYNC_STAGES-1:0] sync_a0;
  logic [SYNC_STAGES-1:0] sync_a1;

  // two-stage capture of pins on mclk
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_rst  <= '1;
      sync_irq0 <= '1;
      sync_irq1 <= '1;
      sync_a0   <= '0;
      sync_a1   <= '0;
    end else if (clk_en) begin
      sync_rst  <= {sync_rst[0], reset_pin_n};
      sync_irq0 <= {sync_irq0[0], irq_in_ch0_n};
      sync_irq1 <= {sync_irq1[0], irq_in_ch1_n};
      sync_a0   <= {sync_a0[0], addr_sel_lo};
      sync_a1   <= {sync_a1[0], addr_sel_hi};
    end
  end

  // ----------------------------------------------------------------
  // reset pin qualification
  // ----------------------------------------------------------------
  logic [RST_CNT_W-1:0] rst_cnt;
  logic                 soft_rst;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt  <= '0;
      soft_rst <= 1'b0;
    end else if (clk_en) begin
      if (sync_rst[1]) begin
        rst_cnt  <= '0;
        soft_rst <= 1'b0;
      end else if (rst_cnt >= RST_CNT_W'(RESET_CYCLES - 1)) begin
        soft_rst <= 1'b1;
      end else begin
        rst_cnt <= rst_cnt + 1'b1;
      end
    end
  end

  // soft reset level into link domain (held from qualification until the pin rises)
  logic [SYNC_STAGES-1:0] link_rst_sync;
  logic                   link_rst;
  assign link_rst = link_rst_sync[1];

  always_ff @(posedge scl_in or negedge rst_n) begin
    if (!rst_n) begin
      link_rst_sync <= '0;
    end else begin
      link_rst_sync <= {link_rst_sync[0], soft_rst};
    end
  end

  // ----------------------------------------------------------------
  // link-domain serial target (clocked by the upstream clock)
  // ----------------------------------------------------------------
  // start and stop are seen on sda edges while scl high
  logic start_tgl;
  logic stop_tgl;

  // start detect: falling data while clock high
  always_ff @(negedge sda_in or negedge rst_n) begin
    if (!rst_n) begin
      start_tgl <= 1'b0;
    end else if (scl_in) begin
      start_tgl <= ~start_tgl;
    end
  end

  // stop detect: rising data while clock high
  always_ff @(posedge sda_in or negedge rst_n) begin
    if (!rst_n) begin
      stop_tgl <= 1'b0;
    end else if (scl_in) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  logic        start_seen;
  logic        start_ack;
  link_state_t state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic        rd_mode;
  logic [7:0]  wr_byte;
  logic        wr_tgl;
  logic [7:0]  rd_byte;
  logic [6:0]  my_addr;
  logic [1:0]  ch_live;

  assign start_seen = start_tgl ^ start_ack;
  // address-select pins form low address bits
  assign my_addr = {ADDR_FIX, sync_a1[1], sync_a0[1]};

  // edge-driven, so any rate up to 400 kHz works
  // receive side on rising clock edges
  always_ff @(posedge scl_in or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      bit_cnt   <= '0;
      shreg     <= '0;
      rd_mode   <= 1'b0;
      wr_byte   <= CTRL_RESET;
      wr_tgl    <= 1'b0;
      start_ack <= 1'b0;
    end else if (link_rst) begin
      state     <= ST_IDLE;
      bit_cnt   <= '0;
      start_ack <= start_tgl;
    end else if (start_seen) begin
      start_ack <= start_tgl;
      state     <= ST_ADDR;
      shreg     <= {7'h00, sda_in};
      bit_cnt   <= 4'h1;
    end else begin
      case (state)
        ST_ADDR: begin
          shreg   <= {shreg[6:0], sda_in};
          bit_cnt <= bit_cnt + 1'b1;
          if (bit_cnt == BIT_COUNT_TOP - 1'b1) begin
            if (shreg[6:0] == my_addr) begin
              state   <= ST_ADDR_ACK;
              rd_mode <= sda_in;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          bit_cnt <= '0;
          state   <= rd_mode ? ST_RD : ST_WR;
        end
        ST_WR: begin
          shreg   <= {shreg[6:0], sda_in};
          bit_cnt <= bit_cnt + 1'b1;
          if (bit_cnt == BIT_COUNT_TOP - 1'b1) begin
            wr_byte <= {shreg[6:0], sda_in};
            wr_tgl  <= ~wr_tgl;
            state   <= ST_WR_ACK;
          end
        end
        ST_WR_ACK: begin
          bit_cnt <= '0;
          state   <= ST_WR;
        end
        ST_RD: begin
          bit_cnt <= bit_cnt + 1'b1;
          if (bit_cnt == BIT_COUNT_TOP - 1'b1) begin
            state <= ST_RD_ACK;
          end
        end
        ST_RD_ACK: begin
          bit_cnt <= '0;
          // master nack ends the read
          state   <= sda_in ? ST_IDLE : ST_RD;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // status captured when read data is loaded
  always_ff @(negedge scl_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_byte <= '0;
    end else if (state == ST_ADDR_ACK || state == ST_RD_ACK) begin
      rd_byte <= {2'b00, ~sync_irq1[1], ~sync_irq0[1], 2'b00, ch_live};
    end
  end

  // drive data on falling clock edges
  always_ff @(negedge scl_in or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      case (state)
        // ack address and each written byte
        ST_ADDR_ACK, ST_WR_ACK: sda_oe <= 1'b1;
        // read data, msb first; a zero bit pulls the line
        ST_RD:                  sda_oe <= ~rd_byte[3'(7 - bit_cnt)];
        // host data bits and the host's ack slot stay released
        default:                sda_oe <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // crossing to mclk: written byte and stop event
  // ----------------------------------------------------------------
  logic [2:0] wr_tgl_sync;
  logic [2:0] stop_sync;
  logic [7:0] ctrl;
  logic       pend_valid;

  // toggle synchronisers for events
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_tgl_sync <= '0;
      stop_sync   <= '0;
    end else if (clk_en) begin
      wr_tgl_sync <= {wr_tgl_sync[1:0], wr_tgl};
      stop_sync   <= {stop_sync[1:0], stop_tgl};
    end
  end

  // channel enables are the two low bits of a control byte
  function automatic logic [1:0] pick_enables(input logic [7:0] b);
    return {b[CH1_EN_POS], b[CH0_EN_POS]};
  endfunction

  // staged control byte, applied at stop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl       <= CTRL_RESET;
      pend_valid <= 1'b0;
      ch_live    <= '0;
    end else if (clk_en && soft_rst) begin
      ctrl       <= CTRL_RESET;
      pend_valid <= 1'b0;
      ch_live    <= '0;
    end else if (clk_en) begin
      // wr_byte stable: toggle lands after byte capture
      if (wr_tgl_sync[2] ^ wr_tgl_sync[1]) begin
        ctrl       <= wr_byte;
        pend_valid <= 1'b1;
      end
      if (stop_sync[2] ^ stop_sync[1]) begin
        pend_valid <= 1'b0;
        // a byte landing in the same cycle as the stop still counts
        if (wr_tgl_sync[2] ^ wr_tgl_sync[1]) begin
          // low two bits only, both allowed
          ch_live <= pick_enables(wr_byte);
        end else if (pend_valid) begin
          ch_live <= pick_enables(ctrl);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // switch enables and interrupt output
  // ----------------------------------------------------------------
  // pass-gate enables follow live selection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      down_clk_ch0_oe  <= 1'b0;
      down_data_ch0_oe <= 1'b0;
      down_clk_ch1_oe  <= 1'b0;
      down_data_ch1_oe <= 1'b0;
      ch0_connected    <= 1'b0;
      ch1_connected    <= 1'b0;
    end else if (clk_en) begin
      down_clk_ch0_oe  <= ch_live[0];
      down_data_ch0_oe <= ch_live[0];
      down_clk_ch1_oe  <= ch_live[1];
      down_data_ch1_oe <= ch_live[1];
      ch0_connected    <= ch_live[0];
      ch1_connected    <= ch_live[1];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
      irq_oe  <= 1'b0;
    end else if (clk_en) begin
      irq_out <= 1'b0;
      irq_oe  <= ~(sync_irq0[1] & sync_irq1[1]);
    end
  end

endmodule // chsw_ctrl

/* File: chsw_ctrl_monitor.sv */
// checker: port-level properties of the switch control block
`timescale 1ns/1ps
module chsw_ctrl_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  input wire logic irq_in_ch0_n,
  input wire logic irq_in_ch1_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic irq_out,
  input wire logic irq_oe,
  input wire logic down_clk_ch0_oe,
  input wire logic down_data_ch0_oe,
  input wire logic down_clk_ch1_oe,
  input wire logic down_data_ch1_oe,
  input wire logic ch0_connected,
  input wire logic ch1_connected
);
  import chsw_pkg::*;
  logic [7:0] since_stop;
  logic [7:0] low_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // cycles since a stop, cycles of reset pin held low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      since_stop <= 8'hff;
      low_cnt    <= 8'h00;
    end else begin
      since_stop <= ($rose(sda_in) && scl_in) ? 8'h00 : since_stop + 8'(since_stop != 8'hff);
      low_cnt    <= reset_pin_n ? 8'h00 : low_cnt + 8'(low_cnt != 8'hff);
    end
  end
  property p_irq_on; (!irq_in_ch0_n || !irq_in_ch1_n) [*4] |-> irq_oe; endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq not pulled");
  property p_irq_off; (irq_in_ch0_n && irq_in_ch1_n) [*4] |-> !irq_oe; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq not released");
  property p_irq_pin; irq_oe |-> !irq_out; endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("irq driven high");
  property p_ch0_path; {down_clk_ch0_oe, down_data_ch0_oe} == {2{ch0_connected}}; endproperty
  a_ch0_path: assert property (p_ch0_path) else $error("ch0 pair mismatch");
  property p_ch1_path; {down_clk_ch1_oe, down_data_ch1_oe} == {2{ch1_connected}}; endproperty
  a_ch1_path: assert property (p_ch1_path) else $error("ch1 pair mismatch");
  property p_rst_idle; $rose(rst_n) |-> !ch0_connected && !ch1_connected && !irq_oe; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle at reset");
  property p_pin_rst; low_cnt == 8'(RESET_CYCLES + 4) |-> !ch0_connected && !ch1_connected;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset kept channel");
  property p_stop_gate; (($changed(ch0_connected) || $changed(ch1_connected)) && reset_pin_n)
    |-> since_stop < 8'h10; endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("selection without stop");
endmodule // chsw_ctrl_monitor
bind chsw_ctrl chsw_ctrl_monitor i_mon (
  .mclk, .rst_n, .reset_pin_n, .irq_in_ch0_n, .irq_in_ch1_n, .scl_in, .sda_in, .irq_out,
  .irq_oe, .down_clk_ch0_oe, .down_data_ch0_oe, .down_clk_ch1_oe, .down_data_ch1_oe,
  .ch0_connected, .ch1_connected
);

/* File: i2c_host_model.sv */
// partner: behavioural upstream serial-bus controller
`timescale 1ns/1ps
module i2c_host_model (
  output logic     scl,
  output logic     sda_drv,
  input wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // one bit at a 15 ns clock
  task automatic bit_io(input logic b, output logic r);
    #3 sda_drv = b;
    #4.5 scl = 1'b1;
    #3.75 r = sda_line;
    #3.75 scl = 1'b0;
  endtask
  task automatic start();
    #30 sda_drv = 1'b0;
    #30 scl = 1'b0;
  endtask
  task automatic stop();
    #3 sda_drv = 1'b0;
    #4.5 scl = 1'b1;
    #30 sda_drv = 1'b1;
    #60;
  endtask
  // byte msb first, then the ninth slot driven with ack_bit
  task automatic byte_io(input logic [7:0] d, input logic ack_bit, output logic [7:0] q,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ack_bit, r);
    ack = !r;
  endtask
endmodule // i2c_host_model

/* File: tb_chsw_ctrl.sv */
// testbench: selection, read-back, interrupts and resets of the switch control
`timescale 1ns/1ps
module tb_chsw_ctrl;
  import chsw_pkg::*;
  logic       mclk = 1'b0, rst_n = 1'b0, reset_pin_n = 1'b1;
  logic [1:0] asel = 2'b10, irq_n = 2'b11, sel = 2'b00;
  logic       scl, sda_m, sda_oe, irq_oe, c0, c1, ok, sda_lo, irq_lvl;
  logic [7:0] q;
  int         failures = 0, cmp_count = 0, cycles = 0;
  chsw_ctrl i_dut (
    .mclk, .rst_n, .clk_en(1'b1), .reset_pin_n, .addr_sel_lo(asel[0]), .addr_sel_hi(asel[1]),
    .irq_in_ch0_n(irq_n[0]), .irq_in_ch1_n(irq_n[1]), .scl_in(scl), .sda_in(sda_m & !sda_oe),
    .sda_out(sda_lo), .sda_oe, .irq_out(irq_lvl), .irq_oe,
    .down_clk_ch0_oe(), .down_data_ch0_oe(),
    .down_clk_ch1_oe(), .down_data_ch1_oe(), .ch0_connected(c0), .ch1_connected(c1)
  );
  i2c_host_model i_host (.scl, .sda_drv(sda_m), .sda_line(sda_m & !sda_oe));
  always #5 mclk = ~mclk;
  // cycle ceiling against a hung transfer
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rd();
    i_host.start();
    i_host.byte_io({ADDR_FIX_DEF, asel, 1'b1}, 1'b1, q, ok);
    check("read ack", 8'h01, {7'h00, ok});
    i_host.byte_io(8'hff, 1'b1, q, ok);
    check("read byte", {2'b00, ~irq_n, 2'b00, sel}, q);
    check("data level", 8'h00, {7'h00, sda_lo});
    i_host.stop();
  endtask
  // optional leading byte, then d; selection must wait for the stop
  task automatic wr(input logic [7:0] d, input bit two);
    i_host.start();
    i_host.byte_io({ADDR_FIX_DEF, asel, 1'b0}, 1'b1, q, ok);
    check("write ack", 8'h01, {7'h00, ok});
    if (two) i_host.byte_io(8'h03, 1'b1, q, ok);
    i_host.byte_io(d, 1'b1, q, ok);
    check("data ack", 8'h01, {7'h00, ok});
    check("sel before stop", {6'h00, sel}, {6'h00, c1, c0});
    i_host.stop();
    repeat (10) @(posedge mclk);
    sel = d[1:0];
    check("sel after stop", {6'h00, sel}, {6'h00, c1, c0});
  endtask
  task automatic t_select();
    check("sel at reset", 8'h00, {6'h00, c1, c0});
    rd();
    for (int i = 1; i < 5; i++) begin
      wr(8'hfc | 8'(i % 4), 1'b0);
      rd();
    end
    wr(8'h02, 1'b1);
    rd();
    $display("done: select");
  endtask
  task automatic t_irq();
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk) irq_n <= 2'(i);
      repeat (6) @(posedge mclk);
      check("irq pull", {7'h00, i != 3}, {7'h00, irq_oe});
      check("irq level", 8'h00, {7'h00, irq_lvl});
      rd();
      wr({6'h00, ~irq_n}, 1'b0);
    end
    $display("done: interrupts");
  endtask
  task automatic t_addr();
    i_host.start();
    i_host.byte_io({ADDR_FIX_DEF, ~asel, 1'b0}, 1'b1, q, ok);
    check("foreign ack", 8'h00, {7'h00, ok});
    i_host.stop();
    @(posedge mclk) asel <= 2'b01;
    repeat (5) @(posedge mclk);
    wr(8'h01, 1'b0);
    rd();
    $display("done: address");
  endtask
  task automatic t_pin();
    wr(8'h03, 1'b0);
    @(posedge mclk) reset_pin_n <= 1'b0;
    repeat (RESET_CYCLES / 2) @(posedge mclk);
    reset_pin_n <= 1'b1;
    repeat (5) @(posedge mclk);
    check("short pulse", 8'h03, {6'h00, c1, c0});
    reset_pin_n <= 1'b0;
    repeat (RESET_CYCLES + 10) @(posedge mclk);
    reset_pin_n <= 1'b1;
    repeat (5) @(posedge mclk);
    check("pin reset", 8'h00, {6'h00, c1, c0});
    sel = 2'b00;
    rd();
    $display("done: reset pin");
  endtask
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_select();
    t_irq();
    t_addr();
    t_pin();
    test_done();
  end
endmodule // tb_chsw_ctrl
